// File: bench/eeprom_link_checker.sv
// Concurrent checks on the two-wire link between target and controller.
module eeprom_link_checker #(
    parameter int PROG_CYC = 400
) (
    // Clock, reset and status
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic busy_o,
    // Link signals
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic sda_ctl_o,
    input wire logic sda_ctl_oe_n,
    input wire logic sda_tgt_o,
    input wire logic sda_tgt_oe_n,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Helper logic
    // ****************************************
    // Program-cycle length; a stuck busy flag overruns the limit.
    int unsigned busy_cnt_ff;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !busy_o)
            busy_cnt_ff <= 0;
        else
            busy_cnt_ff <= busy_cnt_ff + 1;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence start_s;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence stop_s;
        scl && $past(scl) && $rose(sda);
    endsequence
    sequence high_s;
        scl && $past(scl);
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    AST_SCL_LOW_ONLY: assert property (!scl_oe_n |-> !scl_o)
        else $error("clock line driven high");
    AST_CTL_LOW_ONLY: assert property (!sda_ctl_oe_n |-> !sda_ctl_o)
        else $error("controller data driven high");
    AST_TGT_LOW_ONLY: assert property (!sda_tgt_oe_n |-> !sda_tgt_o)
        else $error("target data driven high");
    AST_TGT_STILL: assert property (high_s |-> $stable(sda_tgt_oe_n))
        else $error("target data moved while clock high");
    AST_TGT_ON_LOW: assert property ($fell(sda_tgt_oe_n) |-> !scl)
        else $error("target began driving with clock high");
    AST_BUSY_SILENT: assert property (busy_o |-> sda_tgt_oe_n)
        else $error("target answered while programming");
    AST_BUSY_BOUND: assert property (busy_cnt_ff <= PROG_CYC)
        else $error("program cycle too long");
    AST_BUSY_IDLE: assert property ($rose(busy_o) |-> scl && sda)
        else $error("program cycle began on a busy bus");
    AST_START_FREE: assert property (start_s |-> ##1 sda_tgt_oe_n[*8])
        else $error("target drove during select after start");
    AST_STOP_FREE: assert property (stop_s |-> sda_tgt_oe_n[*4])
        else $error("target drove after stop");
endmodule

// File: bench/test_serial_eeprom_two_wire_target.sv
// Testbench joining the memory target to the bus controller.
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    num_errors++; $display("BAD %0t got %h want %h", $time, got, exp); end end
module test_serial_eeprom_two_wire_target;
    timeunit 1ns;
    timeprecision 1ns;
    import eeprom_link_pkg::*;
    // Short program cycle keeps the run brief.
    localparam int PROG = 400;
    logic       ref_clk_i, reset_i, cmd_valid, guard, busy;
    logic       ready, rd_valid, done, nack;
    cmd_e       cmd;
    logic [2:0] cs, pins;
    logic [7:0] addr, wdata, rd_data;
    logic [3:0] len;
    int         num_errors, num_checks;
    logic [7:0] rdq[$];

    // ****************************************
    // Design under test
    // ****************************************
    eeprom_link_if eeprom_link_if_i ();
    eeprom_target #(.PROG_CYCLES_P(PROG)) eeprom_target_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .chip_select_bit2_i(pins[2]), .chip_select_bit1_i(pins[1]),
        .chip_select_bit0_i(pins[0]), .write_guard_i(guard),
        .busy_o(busy), .link(eeprom_link_if_i));
    eeprom_controller eeprom_controller_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .cmd_cs_i(cs), .cmd_addr_i(addr), .cmd_data_i(wdata),
        .cmd_len_i(len), .cmd_ready_o(ready), .rd_valid_o(rd_valid),
        .rd_data_o(rd_data), .done_o(done), .nack_o(nack),
        .link(eeprom_link_if_i));
    eeprom_link_checker #(.PROG_CYC(PROG)) eeprom_link_checker_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .busy_o(busy),
        .scl_o(eeprom_link_if_i.scl_o), .scl_oe_n(eeprom_link_if_i.scl_oe_n),
        .sda_ctl_o(eeprom_link_if_i.sda_ctl_o),
        .sda_ctl_oe_n(eeprom_link_if_i.sda_ctl_oe_n),
        .sda_tgt_o(eeprom_link_if_i.sda_tgt_o),
        .sda_tgt_oe_n(eeprom_link_if_i.sda_tgt_oe_n),
        .scl(eeprom_link_if_i.scl), .sda(eeprom_link_if_i.sda));

    // Free-running 10 MHz clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // Read bytes are gathered per command.
    always @(posedge ref_clk_i) if (rd_valid === 1'b1) rdq.push_back(rd_data);

    // ****************************************
    // Tasks
    // ****************************************
    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Issues one command and waits a bounded time for its completion.
    task automatic run(input cmd_e c, input logic [2:0] s,
                       input logic [7:0] a, d, input logic [3:0] n);
        int k;
        rdq.delete();
        for (k = 0; k < 50 && ready !== 1'b1; k++) @(posedge ref_clk_i);
        if (k == 50) begin
            `CHK(ready, 1'b1)
            give_verdict();
        end
        cmd_valid <= 1'b1;
        cmd <= c;
        cs <= s;
        addr <= a;
        wdata <= d;
        len <= n;
        @(posedge ref_clk_i);
        cmd_valid <= 1'b0;
        for (k = 0; k < 4000 && done !== 1'b1; k++) @(posedge ref_clk_i);
        if (k == 4000) begin
            `CHK(1'b0, 1'b1)
            give_verdict();
        end
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int k;
        for (k = 0; k < lim && busy !== lvl; k++) @(posedge ref_clk_i);
        `CHK(busy, lvl)
        if (busy !== lvl) give_verdict();
    endtask
    task automatic wr(input logic [7:0] a, d);
        run(CMD_WRITE, 3'h5, a, d, 4'h0);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, PROG + 20);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic poll_write;
        run(CMD_WRITE, 3'h5, 8'h12, 8'h5a, 4'h0);
        `CHK(nack, 1'b0)
        wait_busy(1'b1, 20);
        run(CMD_READ_CUR, 3'h5, 8'h00, 8'h00, 4'h0);
        `CHK(nack, 1'b1)
        wait_busy(1'b0, PROG);
        run(CMD_READ_RAND, 3'h5, 8'h12, 8'h00, 4'h0);
        `CHK(nack, 1'b0)
        `CHK(rdq[0], 8'h5a)
    endtask
    task automatic bad_select;
        run(CMD_READ_RAND, 3'h2, 8'h12, 8'h00, 4'h0);
        `CHK(nack, 1'b1)
    endtask
    task automatic guarded;
        guard <= 1'b1;
        run(CMD_WRITE, 3'h5, 8'h12, 8'ha5, 4'h0);
        repeat (20) @(posedge ref_clk_i);
        `CHK(busy, 1'b0)
        guard <= 1'b0;
        run(CMD_READ_RAND, 3'h5, 8'h12, 8'h00, 4'h0);
        `CHK(rdq[0], 8'h5a)
    endtask
    task automatic counter_reads;
        wr(8'h13, 8'hc3);
        wr(8'hff, 8'h11);
        wr(8'h00, 8'h22);
        run(CMD_READ_RAND, 3'h5, 8'h12, 8'h00, 4'h0);
        run(CMD_READ_CUR, 3'h5, 8'h00, 8'h00, 4'h0);
        `CHK(rdq[0], 8'hc3)
        run(CMD_READ_RAND, 3'h5, 8'hff, 8'h00, 4'h1);
        `CHK(rdq[0], 8'h11)
        `CHK(rdq[1], 8'h22)
    endtask

    // Reset for six cycles, then every scenario in turn.
    initial begin
        reset_i = 1'b1;
        cmd_valid = 1'b0;
        cmd = CMD_WRITE;
        {cs, addr, wdata, len, guard} = '0;
        pins = 3'h5;
        num_errors = 0;
        num_checks = 0;
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        poll_write();
        bad_select();
        guarded();
        counter_reads();
        give_verdict();
    end
endmodule

// File: hw/eeprom_controller.sv
// Two-wire bus controller issuing writes and reads to the memory target.
module eeprom_controller
    import eeprom_link_pkg::*;
#(
    parameter int HALF_BIT = HALF_BIT_DEF
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    // Command
    input  wire logic         cmd_valid_i,
    input  cmd_e              cmd_i,
    input  wire logic [2:0]   cmd_cs_i,
    input  wire logic [7:0]   cmd_addr_i,
    input  wire logic [7:0]   cmd_data_i,
    input  wire logic [3:0]   cmd_len_i,
    // Answer
    output logic              cmd_ready_o,
    output logic              rd_valid_o,
    output logic [7:0]        rd_data_o,
    output logic              done_o,
    output logic              nack_o,
    // Link
    eeprom_link_if.controller link
);

    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {
        C_IDLE, C_START, C_BYTE, C_ACK, C_STOP, C_END
    } cphase_e;

    typedef struct packed {
        logic [1:0] sda_sync;
        cphase_e    phase;
        logic [7:0] tick;
        logic [1:0] quarter;
        logic [3:0] bit_idx;
        logic [7:0] tx;
        logic [7:0] rx;
        logic       reading;
        logic [2:0] step;
        cmd_e       cmd;
        logic [2:0] cs;
        logic [7:0] addr;
        logic [7:0] data;
        logic [3:0] left;
        logic       scl;
        logic       sda;
        logic       ready;
        logic       rd_valid;
        logic       done;
        logic       nack;
    } ctl_s;

    ctl_s r_ff;
    ctl_s nxt_r;
    logic sda_s;
    logic tick_end;

    assign sda_s    = r_ff.sda_sync[1];
    assign tick_end = (r_ff.tick == 8'(HALF_BIT - 1));

    // ****************************************
    // Bit engine: start, stop and each bit phase are four ticked quarters
    // ****************************************
    // Data changes only while the clock is low; start/stop move data
    // with the clock held high.
    always_comb begin
        nxt_r          = r_ff;
        nxt_r.sda_sync = {r_ff.sda_sync[0], link.sda};
        nxt_r.rd_valid = 1'b0;
        nxt_r.done     = 1'b0;
        nxt_r.tick     = tick_end ? 8'h0 : r_ff.tick + 8'h1;
        case (r_ff.phase)
            C_IDLE: begin
                nxt_r.tick  = 8'h0;
                nxt_r.ready = 1'b1;
                if (cmd_valid_i && r_ff.ready) begin
                    nxt_r.ready = 1'b0;
                    nxt_r.cmd   = cmd_i;
                    nxt_r.cs    = cmd_cs_i;
                    nxt_r.addr  = cmd_addr_i;
                    nxt_r.data  = cmd_data_i;
                    nxt_r.left  = cmd_len_i;
                    nxt_r.nack  = 1'b0;
                    nxt_r.step  = 3'h0;
                    nxt_r.phase = C_START;
                    nxt_r.quarter = 2'h0;
                end
            end
            C_START: if (tick_end) begin
                nxt_r.quarter = r_ff.quarter + 2'h1;
                case (r_ff.quarter)
                    2'h0: begin nxt_r.sda = 1'b1; end
                    2'h1: begin nxt_r.scl = 1'b1; end
                    2'h2: begin nxt_r.sda = 1'b0; end
                    default: begin
                        nxt_r.scl     = 1'b0;
                        nxt_r.phase   = C_BYTE;
                        nxt_r.bit_idx = 4'h0;
                        nxt_r.reading = 1'b0;
                        // Select: prefix, chip bits, direction.
                        nxt_r.tx = {TYPE_PREFIX, r_ff.cs,
                                    (r_ff.cmd == CMD_READ_CUR) ||
                                    (r_ff.cmd == CMD_READ_RAND &&
                                     r_ff.step != 3'h0)};
                    end
                endcase
            end
            C_BYTE, C_ACK: if (tick_end) begin
                nxt_r.quarter = r_ff.quarter + 2'h1;
                case (r_ff.quarter)
                    2'h0: begin
                        if (r_ff.phase == C_ACK) begin
                            // Acknowledge ours on read unless last byte.
                            nxt_r.sda = r_ff.reading ?
                                        (r_ff.left == 4'h0) : 1'b1;
                        end else begin
                            nxt_r.sda = r_ff.reading ? 1'b1 : r_ff.tx[7];
                        end
                    end
                    2'h1: begin nxt_r.scl = 1'b1; end
                    2'h2: begin
                        if (r_ff.phase == C_BYTE) begin
                            nxt_r.rx = {r_ff.rx[6:0], sda_s};
                        end else if (!r_ff.reading && sda_s) begin
                            nxt_r.nack = 1'b1;
                        end
                    end
                    default: begin
                        nxt_r.scl = 1'b0;
                        if (r_ff.phase == C_BYTE) begin
                            nxt_r.tx      = {r_ff.tx[6:0], 1'b0};
                            nxt_r.bit_idx = r_ff.bit_idx + 4'h1;
                            if (r_ff.bit_idx == 4'(WORD_BITS - 1)) begin
                                nxt_r.phase = C_ACK;
                                if (r_ff.reading) begin
                                    nxt_r.rd_valid = 1'b1;
                                end
                            end
                        end else begin
                            nxt_r.bit_idx = 4'h0;
                            nxt_r.phase   = C_BYTE;
                            nxt_r.step    = r_ff.step + 3'h1;
                            if (r_ff.nack) begin
                                nxt_r.phase = C_STOP;
                            end else if (r_ff.reading) begin
                                if (r_ff.left == 4'h0) begin
                                    nxt_r.phase = C_STOP;
                                end else begin
                                    nxt_r.left = r_ff.left - 4'h1;
                                end
                            end else if (r_ff.cmd == CMD_READ_RAND &&
                                         r_ff.step == 3'h1) begin
                                // Dummy write done: repeated start.
                                nxt_r.phase = C_START;
                            end else if (r_ff.cmd == CMD_READ_CUR ||
                                         (r_ff.cmd == CMD_READ_RAND &&
                                          r_ff.step == 3'h2)) begin
                                nxt_r.reading = 1'b1;
                            end else if (r_ff.step == 3'h0) begin
                                nxt_r.tx = r_ff.addr;
                            end else if (r_ff.step == 3'h1) begin
                                nxt_r.tx = r_ff.data;
                            end else begin
                                nxt_r.phase = C_STOP;
                            end
                        end
                    end
                endcase
            end
            C_STOP: if (tick_end) begin
                nxt_r.quarter = r_ff.quarter + 2'h1;
                case (r_ff.quarter)
                    2'h0: begin nxt_r.sda = 1'b0; end
                    2'h1: begin nxt_r.scl = 1'b1; end
                    2'h2: begin nxt_r.sda = 1'b1; end
                    default: begin nxt_r.phase = C_END; end
                endcase
            end
            default: begin
                nxt_r.done  = 1'b1;
                nxt_r.phase = C_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            r_ff <= '{sda_sync: 2'h3, phase: C_IDLE, cmd: CMD_WRITE,
                      scl: 1'b1, sda: 1'b1, default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign link.scl_o        = 1'b0;
    assign link.scl_oe_n     = r_ff.scl;
    assign link.sda_ctl_o    = 1'b0;
    assign link.sda_ctl_oe_n = r_ff.sda;
    assign cmd_ready_o       = r_ff.ready;
    assign rd_valid_o        = r_ff.rd_valid;
    assign rd_data_o         = r_ff.rx;
    assign done_o            = r_ff.done;
    assign nack_o            = r_ff.nack;

endmodule

// File: hw/eeprom_link_if.sv
// Two-wire link joining the memory target and the bus controller.
interface eeprom_link_if;
    logic scl_o;
    logic scl_oe_n;
    logic sda_ctl_o;
    logic sda_ctl_oe_n;
    logic sda_tgt_o;
    logic sda_tgt_oe_n;
    wire  scl;
    wire  sda;

    // Open-drain wire level: low when any enabled driver pulls low.
    assign scl = (!scl_oe_n && !scl_o) ? 1'b0 : 1'b1;
    assign sda = ((!sda_ctl_oe_n && !sda_ctl_o) ||
                  (!sda_tgt_oe_n && !sda_tgt_o)) ? 1'b0 : 1'b1;

    modport target (
        input  scl,
        input  sda,
        output sda_tgt_o,
        output sda_tgt_oe_n
    );

    modport controller (
        input  scl,
        input  sda,
        output scl_o,
        output scl_oe_n,
        output sda_ctl_o,
        output sda_ctl_oe_n
    );
endinterface

// File: hw/eeprom_link_pkg.sv
// Shared constants and types for the two-wire memory target and controller.
package eeprom_link_pkg;

    // ****************************************
    // Protocol framing
    // ****************************************
    localparam int          WORD_BITS     = 8;
    localparam logic [3:0]  TYPE_PREFIX   = 4'ha;
    localparam int          PAGE_BITS     = 3;
    localparam int          ADDR_BITS     = 8;
    localparam int          MEM_WORDS     = 256;

    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          PROG_TIME_MS  = 5;
    localparam int          PROG_CYCLES   =
        (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int          HALF_BIT_DEF  = 4;

    // ****************************************
    // Controller command codes
    // ****************************************
    typedef enum logic [1:0] {
        CMD_WRITE,
        CMD_READ_CUR,
        CMD_READ_RAND
    } cmd_e;

endpackage

// File: hw/eeprom_target.sv
// Two-wire memory target: select decode, writes, reads and program cycle.
//
// Overview of operation
// - Every start is followed by an 8-bit select.
// - Upper four select bits must match prefix.
// - Next three bits must match chip-select pins.
// - Select bit zero: one reads, zero writes.
// - Acknowledge on match, else release and idle.
// - Write takes word address then data, acknowledging.
// - Stop after write starts the program cycle.
// - Ignore the bus while programming.
// - Page write accepts up to eight bytes.
// - Write increment touches only low three bits.
// - Select acknowledged again only after programming.
// - Current, random and sequential reads supported.
// - Address counter holds last address plus one, wrapping within the eight-byte page on writes.
// - Read address wraps across whole memory.
// - Current read sends byte at counter address.
// - Random read is dummy write then restart.
// - Controller acknowledge continues sequential read.
// - Start and stop are data edges, clock high.
// - Acknowledge driven low on ninth clock.
// - Program cycle lasts at most five ms.
// - Write-guard high blocks all programming.
module eeprom_target
    import eeprom_link_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    // Pins
    input  wire logic         chip_select_bit2_i,
    input  wire logic         chip_select_bit1_i,
    input  wire logic         chip_select_bit0_i,
    input  wire logic         write_guard_i,
    // Status
    output logic              busy_o,
    // Link
    eeprom_link_if.target     link
);

    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_SELECT, ST_ADDR, ST_WDATA, ST_RDATA, ST_MACK, ST_PROG
    } phase_e;

    typedef struct packed {
        logic [1:0]             scl_sync;
        logic [1:0]             sda_sync;
        logic                   scl_prev;
        logic                   sda_prev;
        phase_e                 phase;
        logic [3:0]             bit_cnt;
        logic [7:0]             shreg;
        logic                   ack_slot;
        logic [ADDR_BITS-1:0]   addr;
        logic [ADDR_BITS-1:0]   wr_base;
        logic [PAGE_BITS:0]     wr_count;
        logic [7:0][7:0]        page_buf;
        logic [1:0][3:0]        pin_sync;
        logic                   pend_write;
        logic [31:0]            prog_cnt;
        logic                   sda_out;
        logic                   sda_oe_n;
        logic                   busy;
    } tgt_s;

    tgt_s r_ff;
    tgt_s nxt_r;
    logic [7:0] mem_ff [0:MEM_WORDS-1];

    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [2:0] cs_pins;
    logic [2:0] wr_lo;

    // Second sync stage feeds the edge logic and the sampled data bit.
    assign scl_s     = r_ff.scl_sync[1];
    assign sda_s     = r_ff.sda_sync[1];
    assign scl_rise  = scl_s && !r_ff.scl_prev;
    assign scl_fall  = !scl_s && r_ff.scl_prev;
    assign start_det = scl_s && r_ff.scl_prev && r_ff.sda_prev && !sda_s;
    assign stop_det  = scl_s && r_ff.scl_prev && !r_ff.sda_prev && sda_s;
    assign cs_pins   = r_ff.pin_sync[1][3:1];

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        nxt_r          = r_ff;
        wr_lo          = 3'h0;
        nxt_r.scl_sync = {r_ff.scl_sync[0], link.scl};
        nxt_r.sda_sync = {r_ff.sda_sync[0], link.sda};
        nxt_r.pin_sync = {r_ff.pin_sync[0], chip_select_bit2_i,
                          chip_select_bit1_i, chip_select_bit0_i,
                          write_guard_i};
        nxt_r.scl_prev = scl_s;
        nxt_r.sda_prev = sda_s;
        nxt_r.busy     = (r_ff.phase == ST_PROG);
        if (r_ff.phase == ST_PROG) begin
            // Bus is ignored until the timer expires.
            nxt_r.sda_oe_n = 1'b1;
            if (r_ff.prog_cnt >= 32'(PROG_CYCLES_P - 1)) begin
                nxt_r.phase = ST_IDLE;
            end else begin
                nxt_r.prog_cnt = r_ff.prog_cnt + 32'h1;
            end
        end else if (start_det) begin
            nxt_r.phase    = ST_SELECT;
            nxt_r.bit_cnt  = 4'h0;
            nxt_r.ack_slot = 1'b0;
            nxt_r.sda_oe_n = 1'b1;
        end else if (stop_det) begin
            nxt_r.sda_oe_n = 1'b1;
            nxt_r.phase    = ST_IDLE;
            if (r_ff.pend_write && !r_ff.pin_sync[1][0]) begin
                nxt_r.phase    = ST_PROG;
                nxt_r.prog_cnt = 32'h0;
            end
            nxt_r.pend_write = 1'b0;
        end else if (r_ff.phase != ST_IDLE && scl_rise) begin
            if (r_ff.ack_slot) begin
                // Ninth clock: sample controller acknowledge on reads.
                if (r_ff.phase == ST_MACK) begin
                    nxt_r.phase = sda_s ? ST_IDLE : ST_MACK;
                end
            end else if (r_ff.phase != ST_RDATA) begin
                nxt_r.shreg   = {r_ff.shreg[6:0], sda_s};
                nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
            end else begin
                nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
            end
        end else if (r_ff.phase != ST_IDLE && scl_fall) begin
            if (r_ff.ack_slot) begin
                // End of ninth clock: release and prepare next word.
                nxt_r.ack_slot = 1'b0;
                nxt_r.bit_cnt  = 4'h0;
                nxt_r.sda_oe_n = 1'b1;
                // Open drain: a one bit is sent by releasing the line.
                if (r_ff.phase == ST_MACK) begin
                    // Controller acknowledged: fetch the next byte.
                    nxt_r.phase    = ST_RDATA;
                    nxt_r.shreg    = mem_ff[r_ff.addr];
                    nxt_r.addr     = r_ff.addr + 8'h1;
                    nxt_r.sda_oe_n = mem_ff[r_ff.addr][7];
                end else if (r_ff.phase == ST_RDATA) begin
                    nxt_r.sda_oe_n = r_ff.shreg[7];
                end
            end else if (r_ff.phase == ST_RDATA) begin
                if (r_ff.bit_cnt == 4'(WORD_BITS)) begin
                    nxt_r.sda_oe_n = 1'b1; // controller owns ack
                    nxt_r.ack_slot = 1'b1;
                    nxt_r.phase    = ST_MACK;
                end else begin
                    nxt_r.shreg   = {r_ff.shreg[6:0], 1'b0};
                    nxt_r.sda_oe_n = r_ff.shreg[6];
                end
            end else if (r_ff.bit_cnt == 4'(WORD_BITS)) begin
                // Word received: decide and acknowledge.
                nxt_r.ack_slot = 1'b1;
                nxt_r.sda_out  = 1'b0;
                nxt_r.sda_oe_n = 1'b0;
                case (r_ff.phase)
                    ST_SELECT: begin
                        if (r_ff.shreg[7:4] != TYPE_PREFIX ||
                            r_ff.shreg[3:1] != cs_pins) begin
                            nxt_r.phase    = ST_IDLE;
                            nxt_r.sda_oe_n = 1'b1;
                            nxt_r.ack_slot = 1'b0;
                        end else if (r_ff.shreg[0]) begin
                            nxt_r.phase = ST_RDATA;
                            nxt_r.shreg = mem_ff[r_ff.addr];
                            nxt_r.addr  = r_ff.addr + 8'h1;
                        end else begin
                            nxt_r.phase = ST_ADDR;
                        end
                    end
                    ST_ADDR: begin
                        nxt_r.addr     = r_ff.shreg;
                        nxt_r.wr_base  = r_ff.shreg;
                        nxt_r.wr_count = '0;
                        nxt_r.phase    = ST_WDATA;
                    end
                    ST_WDATA: begin
                        wr_lo = r_ff.addr[2:0] + 3'h1;
                        nxt_r.page_buf[r_ff.addr[2:0]] = r_ff.shreg;
                        nxt_r.addr       = {r_ff.addr[7:3], wr_lo};
                        nxt_r.pend_write = 1'b1;
                        if (r_ff.wr_count != 4'h8) begin
                            nxt_r.wr_count = r_ff.wr_count + 4'h1;
                        end
                    end
                    default: begin
                        nxt_r.phase = ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Registers and array
    // ****************************************
    // Page buffer commits the whole touched window at program start.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            r_ff.scl_sync   <= 2'h3;
            r_ff.sda_sync   <= 2'h3;
            r_ff.scl_prev   <= 1'b1;
            r_ff.sda_prev   <= 1'b1;
            r_ff.phase      <= ST_IDLE;
            r_ff.bit_cnt    <= 4'h0;
            r_ff.shreg      <= 8'h00;
            r_ff.ack_slot   <= 1'b0;
            r_ff.addr       <= 8'h00;
            r_ff.wr_base    <= 8'h00;
            r_ff.wr_count   <= 4'h0;
            r_ff.page_buf   <= '0;
            r_ff.pin_sync   <= '0;
            r_ff.pend_write <= 1'b0;
            r_ff.prog_cnt   <= 32'h0;
            r_ff.sda_out    <= 1'b1;
            r_ff.sda_oe_n   <= 1'b1;
            r_ff.busy       <= 1'b0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // The array is nonvolatile: reset does not clear it.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_i && r_ff.phase != ST_PROG && nxt_r.phase == ST_PROG) begin
            for (int i = 0; i < 8; i++) begin
                if (4'(i) < r_ff.wr_count) begin
                    mem_ff[{r_ff.wr_base[7:3],
                            3'(r_ff.wr_base[2:0] + 3'(i))}] <=
                        r_ff.page_buf[3'(r_ff.wr_base[2:0] + 3'(i))];
                end
            end
        end
    end

    assign link.sda_tgt_o    = r_ff.sda_out;
    assign link.sda_tgt_oe_n = r_ff.sda_oe_n;
    assign busy_o            = r_ff.busy;

endmodule
